// File: dv/rfack_air_model.sv
`timescale 1ns/1ps
// ------------------------------
// Remote node on the air
// ------------------------------
module rfack_air_model (
  input  wire logic       ref_clk,
  input  wire logic       ackTxStart,
  output logic            shrDetect,
  output logic            phrValid,
  output logic      [7:0] frameRssi,
  output logic            interfererDet,
  output logic            lastSymbol,
  output logic            fcsValid,
  output logic            frameReserved,
  output logic            frameDataCmd,
  output logic            addrMatch,
  output logic            ackRequest,
  output logic            ackTxDone
);
  int txLen = 20;
  int txCnt = 0;
  initial begin
    {shrDetect, phrValid, interfererDet, lastSymbol} = 4'h0;
    {fcsValid, frameReserved, frameDataCmd, addrMatch} = 4'h0;
    {ackRequest, ackTxDone} = 2'b00;
    frameRssi = 8'h00;
  end
  // Ack air time; raise txLen for a slow radio
  always @(posedge ref_clk) begin
    if (ackTxStart === 1'b1) begin
      txCnt <= txLen;
    end else if (txCnt > 0) begin
      txCnt <= txCnt - 1;
    end
    ackTxDone <= (txCnt > 0) && (txCnt < 4);
  end
  task automatic frame(input logic [7:0] rssi,
                       input logic fcs, res, hit, req);
    @(posedge ref_clk);
    {shrDetect, phrValid, frameReserved, frameDataCmd} <= {2'b11, res, !res};
    {addrMatch, ackRequest} <= {hit, req};
    frameRssi <= rssi;
    repeat (10) @(posedge ref_clk);
    // Preamble gone by the last symbol, so no false restart behind it
    {shrDetect, lastSymbol, fcsValid} <= {1'b0, 1'b1, fcs};
    repeat (3) @(posedge ref_clk);
    {shrDetect, phrValid, lastSymbol, fcsValid} <= 4'h0;
    repeat (4) @(posedge ref_clk);
    // Released RSSI shows the inverse, never the stale value; frame flags drop to zero
    frameRssi <= ~rssi;
    {frameReserved, frameDataCmd, addrMatch, ackRequest} <= 4'h0;
  endtask
  task automatic intf;
    @(posedge ref_clk);
    interfererDet <= 1'b1;
    @(posedge ref_clk);
    interfererDet <= 1'b0;
  endtask
endmodule

// File: dv/rfack_ctrl_tb.sv
`timescale 1ns/1ps
`include "rfack_cfg.svh"
module rfack_ctrl_tb;
  logic       ref_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [8:0] regAddr = 9'h000;
  logic [7:0] regWrData = 8'h00;
  logic       regWr = 1'b0;
  logic       regRd = 1'b0;
  logic       autoAckMode = 1'b0;
  logic       ackSuppress = 1'b0;
  logic       slottedAck = 1'b0;
  logic       phyRxActive = 1'b1;
  logic [7:0] signalFloor = 8'h0a;
  logic [7:0] regRdData, frameRssi;
  logic [1:0] restartOption;
  logic [3:0] loadCapTrim;
  logic       shrDetect, phrValid, interfererDet, lastSymbol, fcsValid;
  logic       frameReserved, frameDataCmd, addrMatch, ackRequest, ackTxDone;
  logic       rxStart, rxRestart, frameEndEvent, addressMatchEvent;
  logic       fcsGoodFlag, ackTxStart, ackTxActive;
  int         mismatches = 0;
  int         check_count = 0;
  int         nStart, nRestart, nEnd, nMatch, nAck, cyc, tEnd, tAck, exp;
  always #25 ref_clk = ~ref_clk;
  rfack_ctrl dut_u (.*);
  rfack_air_model air_u (.*);
  // ------------------------------
  // Event counters
  // ------------------------------
  always @(posedge ref_clk) begin
    cyc++;
    nStart += (rxStart === 1'b1);
    nRestart += (rxRestart === 1'b1);
    nMatch += (addressMatchEvent === 1'b1);
    if (frameEndEvent === 1'b1) begin
      nEnd++;
      tEnd = cyc;
    end
    if (ackTxStart === 1'b1) begin
      nAck++;
      tAck = cyc;
    end
  end
  // ------------------------------
  // Access tasks
  // ------------------------------
  task automatic chk(input string what, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {regWr, regAddr, regWrData} <= {1'b1, a, d};
    @(posedge ref_clk);
    regWr <= 1'b0;
    // Let the register update settle before callers compare outputs
    #1;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    {regRd, regAddr} <= {1'b1, a};
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 chk("read data", 16'(e), 16'(regRdData));
  endtask
  // Counters cleared off the edge to avoid racing the monitor
  task automatic clr;
    @(negedge ref_clk);
    {nStart, nRestart, nEnd, nMatch, nAck} = '0;
  endtask
  task automatic frm(input logic [7:0] r, input logic f, s, h, q);
    air_u.frame(r, f, s, h, q);
    repeat (30) @(posedge ref_clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge ref_clk);
    mismatches++;
    report_and_stop();
  end
  // ------------------------------
  // Tests
  // ------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(`RFACK_OFS_SYNC, `RFACK_SYN_RST);
    rd(`RFACK_OFS_AACK, `RFACK_AACK_RST);
    rd(9'h100, 8'h00);
    chk("trim reset", 16'h0, 16'(loadCapTrim));
    wr(`RFACK_OFS_AACK, 8'h36);
    rd(`RFACK_OFS_AACK, 8'h36);
    for (int c = 0; c < 16; c += 5) begin
      wr(`RFACK_OFS_TRIM, 8'(c));
      chk("trim code", 16'(c), 16'(loadCapTrim));
    end
    for (int o = 0; o < 4; o++) begin
      wr(`RFACK_OFS_SYNC, {2'b01, 2'(o), 4'h0});
      chk("restart option", 16'(o), 16'(restartOption));
    end
    wr(`RFACK_OFS_AACK, 8'h00);
    wr(`RFACK_OFS_SYNC, 8'h40);
    clr();
    frm(8'h00, 1'b1, 1'b0, 1'b0, 1'b0);
    chk("weak frame taken", 16'h1, 16'(nStart));
    chk("fcs flag", 16'h1, 16'(fcsGoodFlag));
    // Threshold 0x0a + 3 * 2 = 0x10
    wr(`RFACK_OFS_SYNC, 8'h43);
    clr();
    frm(8'h0f, 1'b1, 1'b0, 1'b0, 1'b0);
    frm(8'h10, 1'b1, 1'b0, 1'b0, 1'b0);
    chk("threshold", 16'h1, 16'(nStart));
    wr(`RFACK_OFS_SYNC, 8'hc0);
    clr();
    frm(8'hff, 1'b1, 1'b0, 1'b0, 1'b0);
    wr(`RFACK_OFS_SYNC, 8'hc3);
    frm(8'hff, 1'b1, 1'b0, 1'b0, 1'b0);
    chk("blocked", 16'h0, 16'(nStart));
    wr(`RFACK_OFS_SYNC, 8'h40);
    clr();
    fork
      air_u.frame(8'h20, 1'b1, 1'b0, 1'b0, 1'b0);
      begin
        repeat (6) @(posedge ref_clk);
        wr(`RFACK_OFS_SYNC, 8'hc0);
      end
    join
    repeat (30) @(posedge ref_clk);
    chk("late block", 16'h1, 16'(nEnd));
    for (int e = 0; e < 2; e++) begin
      wr(`RFACK_OFS_SYNC, {1'b0, 1'(e), 6'h00});
      clr();
      fork
        frm(8'h20, 1'b1, 1'b0, 1'b0, 1'b0);
        begin
          repeat (6) @(posedge ref_clk);
          air_u.intf();
        end
      join
      chk("interferer", 16'(e), 16'(nRestart));
    end
    autoAckMode <= 1'b1;
    wr(`RFACK_OFS_AACK, 8'h02);
    clr();
    frm(8'h20, 1'b0, 1'b0, 1'b0, 1'b0);
    chk("promiscuous end", 16'h1, 16'(nEnd));
    chk("bad fcs flag", 16'h0, 16'(fcsGoodFlag));
    wr(`RFACK_OFS_AACK, 8'h00);
    clr();
    frm(8'h20, 1'b1, 1'b1, 1'b1, 1'b0);
    chk("reserved dropped", 16'h0, 16'(nEnd));
    wr(`RFACK_OFS_AACK, 8'h30);
    ackSuppress <= 1'b1;
    clr();
    frm(8'h20, 1'b1, 1'b1, 1'b1, 1'b1);
    repeat (4000) @(posedge ref_clk);
    chk("reserved end", 16'h1, 16'(nEnd));
    chk("address match", 16'h1, 16'(nMatch));
    chk("ack suppressed", 16'h0, 16'(nAck));
    ackSuppress <= 1'b0;
    // Long delay with reserved filtering, then short delay with promiscuous on, unslotted and slotted
    for (int s = 0; s < 3; s++) begin
      wr(`RFACK_OFS_AACK, s == 0 ? 8'h30 : 8'h06);
      slottedAck <= (s == 2);
      clr();
      frm(8'h20, 1'b1, s == 0, 1'b1, 1'b1);
      for (int w = 0; w < 4500 && nAck == 0; w++) @(posedge ref_clk);
      chk("ack sent", 16'h1, 16'(nAck));
      exp = (s == 0 ? `RFACK_TURN_LONG : `RFACK_TURN_SHORT) * `RFACK_SYM_CYC;
      chk("ack delay", 16'h1, 16'(tAck - tEnd inside {[exp-8:exp+8]}));
      repeat (60) @(posedge ref_clk);
    end
    report_and_stop();
  end
endmodule

// File: inc/rfack_cfg.svh
`ifndef RFACK_CFG_SVH
`define RFACK_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RFACK_OFS_SYNC    9'h155
`define RFACK_OFS_AACK    9'h157
`define RFACK_OFS_TRIM    9'h152
// ----------------------------------------
// Field positions
// ----------------------------------------
`define RFACK_SYN_BLOCK   7
`define RFACK_SYN_RESTART 6
`define RFACK_SYN_OPT_HI  5
`define RFACK_SYN_OPT_LO  4
`define RFACK_AACK_FLT    5
`define RFACK_AACK_UPLD   4
`define RFACK_AACK_SHORT  2
`define RFACK_AACK_PROM   1
// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define RFACK_SYN_RST     8'h40
`define RFACK_AACK_RST    8'h00
`define RFACK_AACK_WMASK  8'h36
`define RFACK_TRIM_RST    4'h0
// ----------------------------------------
// Timing
// ----------------------------------------
`define RFACK_CLK_MHZ     20
`define RFACK_SYM_NS      16000
`define RFACK_SYM_CYC     ((`RFACK_SYM_NS * `RFACK_CLK_MHZ) / 1000)
`define RFACK_TURN_LONG   12
`define RFACK_TURN_SHORT  2
`define RFACK_RSSI_STEP   3
`endif

// File: inc/rfack_pkg.sv
package rfack_pkg;
  typedef enum logic [3:0] {
    RFACK_IDLE = 4'h1,
    RFACK_RECV = 4'h2,
    RFACK_TURN = 4'h4,
    RFACK_SEND = 4'h8
  } rfack_state_t;
endpackage

// File: src/rfack_ctrl.sv
`timescale 1ns/1ps
`include "rfack_cfg.svh"
// Function
// R01: While frame_rx_block is set, no new frame reception starts.
// R02: Setting frame_rx_block mid-frame leaves that frame running.
// R03: Blocking works whatever the sensitivity threshold level is.
// R04: With restart enabled, an interferer abandons and restarts reception.
// R05: Two-bit restart option field in bits 5:4 selects restart variant.
// R06: Nonzero level drops frames with RSSI below floor plus 3*(level-1).
// R07: Level zero receives every frame with valid SHR and PHR.
// R08: Reserved-type accept: process reserved frames, frame end when FCS good.
// R09: Reserved filter on: address filtering like data; off: FCS check only.
// R10: Software sets reserved filter only while reserved accept is set.
// R11: Auto-ack mode, reserved filtering: address match event on address hit.
// R12: Filtered reserved frame requesting ack gets ack unless suppressed.
// R13: Ack starts 12 symbols after last symbol, or 2 with short delay.
// R14: Short delay selection also governs slotted acknowledgment response time.
// R15: Promiscuous: every valid-PHR frame ends with frame end event.
// R16: Promiscuous operation still updates the FCS good flag.
// R17: Promiscuous: frame passing filter still gets ack unless suppressed.
// R18: Reserved bits written with reset value; reads undefined (read zero).
// R19: Four-bit load trim code selects 0.3 pF steps; zero disconnects.
// R20: Threshold and filter changes apply to frames starting after write.
module rfack_ctrl (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic [8:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdData,
  input  wire logic       autoAckMode,
  input  wire logic       ackSuppress,
  input  wire logic       slottedAck,
  input  wire logic [7:0] signalFloor,
  input  wire logic       phyRxActive,
  input  wire logic       shrDetect,
  input  wire logic       phrValid,
  input  wire logic [7:0] frameRssi,
  input  wire logic       interfererDet,
  input  wire logic       lastSymbol,
  input  wire logic       fcsValid,
  input  wire logic       frameReserved,
  input  wire logic       frameDataCmd,
  input  wire logic       addrMatch,
  input  wire logic       ackRequest,
  input  wire logic       ackTxDone,
  output logic            rxStart,
  output logic            rxRestart,
  output logic      [1:0] restartOption,
  output logic            frameEndEvent,
  output logic            addressMatchEvent,
  output logic            fcsGoodFlag,
  output logic            ackTxStart,
  output logic            ackTxActive,
  output logic      [3:0] loadCapTrim
);
  // ----------------------------------------
  // Timing constants
  // ----------------------------------------
  // Nine bits: one symbol is more than 255 clocks
  localparam logic [8:0] SYM_CYC = 9'(`RFACK_SYM_CYC);
  localparam logic [3:0] TURN_L  = 4'(`RFACK_TURN_LONG);
  localparam logic [3:0] TURN_S  = 4'(`RFACK_TURN_SHORT);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic                  block;
    logic                  restartEn;
    logic [1:0]            restartOpt;
    logic [3:0]            level;
    logic                  fltRes;
    logic                  upldRes;
    logic                  shortAck;
    logic                  prom;
    logic [3:0]            trim;
    // Settings latched at frame start
    logic [3:0]            fLevel;
    logic                  fFltRes;
    logic                  fUpldRes;
    logic                  fProm;
    logic                  fShort;
    logic                  ackPend;
    rfack_pkg::rfack_state_t st;
    logic [8:0]            symCnt;
    logic [3:0]            turnCnt;
    logic [7:0]            rdData;
    logic                  frameEnd;
    logic                  amEvt;
    logic                  fcsGood;
    logic                  ackStart;
    logic                  rxStartP;
    logic                  restartP;
  } rfack_state_s_t;

  rfack_state_s_t s_ff;
  rfack_state_s_t nxt_s;

  // Eight pin-side flags through two flops; frameRssi, frameReserved, frameDataCmd and phyRxActive are used directly
  logic [7:0] sync1_ff;
  logic [7:0] sync2_ff;
  wire  [7:0] syncIn = {shrDetect, phrValid, interfererDet, lastSymbol,
                        fcsValid, addrMatch, ackRequest, ackTxDone};
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
    end else begin
      sync1_ff <= syncIn;
      sync2_ff <= sync1_ff;
    end
  end
  wire sShr  = sync2_ff[7];
  wire sPhr  = sync2_ff[6];
  wire sIntf = sync2_ff[5];
  wire sLast = sync2_ff[4];
  wire sFcs  = sync2_ff[3];
  wire sAddr = sync2_ff[2];
  wire sAckR = sync2_ff[1];
  wire sTxD  = sync2_ff[0];

  // ----------------------------------------
  // Combinational next state
  // ----------------------------------------
  logic [8:0] thresh;
  logic       rssiOk;
  logic       resFlt;
  logic       resOk;
  logic       filtPass;
  logic       endOk;
  logic [3:0] turnSel;
  always_comb begin
    nxt_s = s_ff;
    nxt_s.frameEnd = 1'b0;
    nxt_s.amEvt    = 1'b0;
    nxt_s.ackStart = 1'b0;
    nxt_s.rxStartP = 1'b0;
    nxt_s.restartP = 1'b0;
    nxt_s.rdData   = 8'h00;
    // Start decision uses the live level; wrap at level 0 is masked below
    thresh = 9'({1'b0, signalFloor})
           + 9'(`RFACK_RSSI_STEP) * 9'(s_ff.level - 4'h1);  // see R06
    rssiOk = (s_ff.level == 4'h0) ||                         // see R07
             ({1'b0, frameRssi} >= thresh);                  // see R06
    resFlt = frameReserved && s_ff.fUpldRes && s_ff.fFltRes;
    // Reserved frames need accept; filter uses address match
    resOk = !frameReserved || s_ff.fUpldRes;                 // see R08
    filtPass = autoAckMode && sAddr &&
               (frameDataCmd || resFlt);                     // see R09
    endOk = (s_ff.fProm && autoAckMode) ||                   // see R15
            (resOk && sFcs &&
             (!frameReserved || !s_ff.fFltRes || !autoAckMode || sAddr));
    turnSel = s_ff.fShort ? TURN_S : TURN_L;                 // see R13 R14
    // Register writes
    if (regWr) begin
      unique case (regAddr)
        `RFACK_OFS_SYNC: begin
          nxt_s.block      = regWrData[`RFACK_SYN_BLOCK];
          nxt_s.restartEn  = regWrData[`RFACK_SYN_RESTART];
          nxt_s.restartOpt = regWrData[`RFACK_SYN_OPT_HI:`RFACK_SYN_OPT_LO];
          nxt_s.level      = regWrData[3:0];
        end
        `RFACK_OFS_AACK: begin
          // Reserved bits stay at reset value
          nxt_s.fltRes   = regWrData[`RFACK_AACK_FLT];            // see R18
          nxt_s.upldRes  = regWrData[`RFACK_AACK_UPLD];
          nxt_s.shortAck = regWrData[`RFACK_AACK_SHORT];
          nxt_s.prom     = regWrData[`RFACK_AACK_PROM];
        end
        `RFACK_OFS_TRIM: nxt_s.trim = regWrData[3:0];             // see R19
        default: ;
      endcase
    end
    if (regRd) begin
      unique case (regAddr)
        `RFACK_OFS_SYNC: nxt_s.rdData = {s_ff.block, s_ff.restartEn,
                                         s_ff.restartOpt, s_ff.level};
        `RFACK_OFS_AACK: nxt_s.rdData = {2'b00, s_ff.fltRes, s_ff.upldRes,
                                         1'b0, s_ff.shortAck, s_ff.prom,
                                         1'b0} & `RFACK_AACK_WMASK;
        `RFACK_OFS_TRIM: nxt_s.rdData = {4'h0, s_ff.trim};
        default:         nxt_s.rdData = 8'h00;
      endcase
    end
    // Frame sequencing
    unique case (s_ff.st)
      rfack_pkg::RFACK_IDLE: begin
        // Block gates only new starts, independent of level
        if (phyRxActive && sShr && !s_ff.block && rssiOk) begin // see R01 R03
          nxt_s.st       = rfack_pkg::RFACK_RECV;
          nxt_s.rxStartP = 1'b1;
          nxt_s.fLevel   = s_ff.level;                          // see R20
          nxt_s.fFltRes  = s_ff.fltRes;
          nxt_s.fUpldRes = s_ff.upldRes;
          nxt_s.fProm    = s_ff.prom;
          nxt_s.fShort   = s_ff.shortAck;
          nxt_s.ackPend  = 1'b0;
        end
      end
      rfack_pkg::RFACK_RECV: begin
        // Block bit not checked here: ongoing frame survives
        if (s_ff.restartEn && sIntf) begin                      // see R02 R04
          nxt_s.restartP = 1'b1;
          nxt_s.st       = rfack_pkg::RFACK_IDLE;
        end else if (sLast && sPhr) begin
          nxt_s.fcsGood  = sFcs;                                // see R16
          nxt_s.frameEnd = endOk;                               // see R08 R15
          nxt_s.amEvt    = filtPass && resFlt;                  // see R11
          nxt_s.ackPend  = filtPass && sFcs && sAckR &&
                           !ackSuppress;                        // see R12 R17
          nxt_s.symCnt   = 9'h000;
          nxt_s.turnCnt  = 4'h0;
          nxt_s.st = (filtPass && sFcs && sAckR && !ackSuppress)
                   ? rfack_pkg::RFACK_TURN : rfack_pkg::RFACK_IDLE;
        end else if (sLast) begin
          nxt_s.st = rfack_pkg::RFACK_IDLE;
        end
      end
      rfack_pkg::RFACK_TURN: begin
        // Symbol timebase; slotted mode shares the same delay
        if (s_ff.symCnt == SYM_CYC - 9'h001) begin              // see R14
          nxt_s.symCnt  = 9'h000;
          nxt_s.turnCnt = s_ff.turnCnt + 4'h1;
          if (s_ff.turnCnt + 4'h1 == turnSel) begin             // see R13
            nxt_s.ackStart = 1'b1;
            nxt_s.st       = rfack_pkg::RFACK_SEND;
          end
        end else begin
          nxt_s.symCnt = s_ff.symCnt + 9'h001;
        end
      end
      rfack_pkg::RFACK_SEND: begin
        if (sTxD) begin
          nxt_s.ackPend = 1'b0;
          nxt_s.st      = rfack_pkg::RFACK_IDLE;
        end
      end
      default: nxt_s.st = rfack_pkg::RFACK_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_ff            <= '0;
      s_ff.restartEn  <= 1'(`RFACK_SYN_RST >> `RFACK_SYN_RESTART);
      s_ff.trim       <= `RFACK_TRIM_RST;
      s_ff.st         <= rfack_pkg::RFACK_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign regRdData         = s_ff.rdData;
  assign rxStart           = s_ff.rxStartP;
  assign rxRestart         = s_ff.restartP;
  assign restartOption     = s_ff.restartOpt;                    // see R05
  assign frameEndEvent     = s_ff.frameEnd;
  assign addressMatchEvent = s_ff.amEvt;
  assign fcsGoodFlag       = s_ff.fcsGood;
  assign ackTxStart        = s_ff.ackStart;
  assign ackTxActive       = (s_ff.st == rfack_pkg::RFACK_SEND);
  assign loadCapTrim       = s_ff.trim;                          // see R19

  // ----------------------------------------
  // Check helpers
  // ----------------------------------------
  // Turnaround spans run to thousands of clocks, too long to unroll
  localparam logic [11:0] TURN_L_CYC =
    12'(`RFACK_TURN_LONG * `RFACK_SYM_CYC);
  localparam logic [11:0] TURN_S_CYC =
    12'(`RFACK_TURN_SHORT * `RFACK_SYM_CYC);

  // Clocks spent in turnaround; holds its count into the send cycle
  logic [11:0] turnAge_ff;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      turnAge_ff <= 12'h000;
    end else if (s_ff.st == rfack_pkg::RFACK_TURN) begin
      turnAge_ff <= turnAge_ff + 12'h001;
    end else begin
      turnAge_ff <= 12'h000;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_block;
    @(posedge ref_clk) disable iff (!reset_n)
      s_ff.block |=> !s_ff.rxStartP;
  endproperty
  a_block: assert property (p_block) else $error("start while blocked"); // see R01

  property p_keep;
    @(posedge ref_clk) disable iff (!reset_n)
      (s_ff.st == rfack_pkg::RFACK_RECV && !s_ff.restartEn && !sLast)
        |=> s_ff.st == rfack_pkg::RFACK_RECV;
  endproperty
  a_keep: assert property (p_keep) else $error("frame aborted"); // see R02

  property p_restart;
    @(posedge ref_clk) disable iff (!reset_n)
      (s_ff.st == rfack_pkg::RFACK_RECV && s_ff.restartEn && sIntf)
        |=> s_ff.restartP && s_ff.st == rfack_pkg::RFACK_IDLE;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart"); // see R04

  property p_turn_long;
    @(posedge ref_clk) disable iff (!reset_n)
      (s_ff.ackStart && !s_ff.fShort) |-> turnAge_ff == TURN_L_CYC;
  endproperty
  a_turn_long: assert property (p_turn_long) else $error("long turn"); // see R13

  property p_turn_short;
    @(posedge ref_clk) disable iff (!reset_n)
      (s_ff.ackStart && s_ff.fShort) |-> turnAge_ff == TURN_S_CYC;
  endproperty
  a_turn_short: assert property (p_turn_short) else $error("short turn"); // see R14

  // Catches a turnaround that never ends as well as a late one
  property p_turn_bound;
    @(posedge ref_clk) disable iff (!reset_n)
      (s_ff.st == rfack_pkg::RFACK_TURN)
        |-> turnAge_ff < (s_ff.fShort ? TURN_S_CYC : TURN_L_CYC);
  endproperty
  a_turn_bound: assert property (p_turn_bound) else $error("turn overrun"); // see R13

  property p_block_idle;
    @(posedge ref_clk) disable iff (!reset_n)
      (s_ff.st == rfack_pkg::RFACK_IDLE && s_ff.block)
        |=> s_ff.st == rfack_pkg::RFACK_IDLE;
  endproperty
  a_block_idle: assert property (p_block_idle) else $error("left idle"); // see R01

  property p_rd_zero;
    @(posedge ref_clk) disable iff (!reset_n)
      !regRd |=> regRdData == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("stray read data"); // see R18

  property p_trim;
    @(posedge ref_clk) disable iff (!reset_n)
      (regWr && regAddr == `RFACK_OFS_TRIM)
        |=> loadCapTrim == $past(regWrData[3:0]);
  endproperty
  a_trim: assert property (p_trim) else $error("trim not taken"); // see R19

  // Reserved frames without accept must not end, promiscuous aside
  property p_res_drop;
    @(posedge ref_clk) disable iff (!reset_n)
      (s_ff.st == rfack_pkg::RFACK_RECV && !(s_ff.restartEn && sIntf)
       && sLast && sPhr && frameReserved && !s_ff.fUpldRes
       && !(s_ff.fProm && autoAckMode)) |=> !s_ff.frameEnd;
  endproperty
  a_res_drop: assert property (p_res_drop) else $error("reserved ended"); // see R08

  property p_supp;
    @(posedge ref_clk) disable iff (!reset_n)
      (s_ff.st == rfack_pkg::RFACK_RECV && ackSuppress) |=>
        s_ff.st != rfack_pkg::RFACK_TURN;
  endproperty
  a_supp: assert property (p_supp) else $error("ack not suppressed"); // see R12

  property p_prom;
    @(posedge ref_clk) disable iff (!reset_n)
      (s_ff.st == rfack_pkg::RFACK_RECV && !(s_ff.restartEn && sIntf)
       && sLast && sPhr && s_ff.fProm && autoAckMode) |=> s_ff.frameEnd;
  endproperty
  a_prom: assert property (p_prom) else $error("promisc end lost"); // see R15

  property p_fcs;
    @(posedge ref_clk) disable iff (!reset_n)
      (s_ff.st == rfack_pkg::RFACK_RECV && !(s_ff.restartEn && sIntf)
       && sLast && sPhr) |=> s_ff.fcsGood == $past(sFcs);
  endproperty
  a_fcs: assert property (p_fcs) else $error("fcs flag stale"); // see R16
endmodule
